/* eq_pkg.sv */
// eq_pkg: constants, types and helpers of the five-band equaliser
// assumes 16-bit control registers reached by word index
package eq_pkg;
	localparam int SAMPLE_W  = 24;
	localparam int DATA_W    = 28;
	localparam int COEF_W    = 16;
	localparam int GM1_W     = 18;
	localparam int FRAC_W    = 14;
	localparam int NUM_BANDS = 5;
	localparam int GCODE_W   = 5;
	localparam int NUM_CUST  = 18;
	localparam int REG_W     = 16;
	localparam int IDX_W     = 8;
	localparam int WB_DAT_W  = 32;
	localparam int WB_ADR_W  = 12;

	localparam logic [IDX_W-1:0] IDX_CTRL_ONE   = 8'h2a;
	localparam logic [IDX_W-1:0] IDX_CTRL_TWO   = 8'h2b;
	localparam logic [IDX_W-1:0] IDX_CUST_FIRST = 8'h2c;
	localparam logic [IDX_W-1:0] IDX_CUST_LAST  = 8'h3d;
	localparam logic [IDX_W-1:0] IDX_MODE       = 8'h3e;
	localparam logic [IDX_W-1:0] IDX_STATUS     = 8'h3f;

	localparam int ENA_POS   = 0;
	localparam int B1_POS    = 11;
	localparam int B2_POS    = 6;
	localparam int B3_POS    = 1;
	localparam int B4_POS    = 11;
	localparam int B5_POS    = 6;
	localparam int MODE_POS  = 0;
	localparam int BUSY_POS  = 0;
	localparam int HOLD_POS  = 1;

	localparam logic [REG_W-1:0] CTRL_ONE_RST  = 16'h0000;
	localparam logic [REG_W-1:0] CTRL_TWO_RST  = 16'h0000;
	localparam logic [REG_W-1:0] MODE_RST      = 16'h0000;
	localparam logic [REG_W-1:0] CUST_RST      = 16'h0000;
	localparam logic [REG_W-1:0] CTRL_TWO_MASK = 16'hffc0;
	localparam logic [REG_W-1:0] MODE_MASK     = 16'h0001;

	localparam logic [GCODE_W-1:0] GCODE_MAX  = 5'h18;
	localparam logic [GCODE_W-1:0] GCODE_FLAT = 5'h0c;

	typedef enum logic [1:0] {BT_LOW_SHELF = 2'b00, BT_PEAK = 2'b01, BT_HIGH_SHELF = 2'b10} band_type_t;
	typedef logic signed [COEF_W-1:0] coef_t;
	typedef logic signed [GM1_W-1:0]  gm1_t;
	typedef logic signed [DATA_W-1:0] data_t;

	localparam band_type_t BAND_TYPE [NUM_BANDS] = '{BT_LOW_SHELF, BT_PEAK, BT_PEAK, BT_PEAK, BT_HIGH_SHELF};
	// normalised to fs, so band frequencies track the sample rate
	localparam coef_t DEF_B0 [NUM_BANDS] = '{16'sh00d5, 16'sh013b, 16'sh0376, 16'sh0891, 16'sh19f0};
	localparam coef_t DEF_A1 [NUM_BANDS] = '{-16'sh3f2b, -16'sh7d71, -16'sh784a, -16'sh6972, -16'sh19f0};
	localparam coef_t DEF_A2 [NUM_BANDS] = '{16'sh0000, 16'sh3d89, 16'sh3915, 16'sh2edf, 16'sh0000};
	// linear gain minus one, codes 0 to 24
	localparam gm1_t GAIN_M1 [25] = '{
		-18'sh2fec, -18'sh2df6, -18'sh2bc3, -18'sh294b, -18'sh2685,
		-18'sh236a, -18'sh1fed, -18'sh1c03, -18'sh179e, -18'sh12b1,
		-18'sh0d2a, -18'sh06f6, 18'sh0000, 18'sh07cf, 18'sh1092,
		18'sh1a67, 18'sh256f, 18'sh31cf, 18'sh3fb2, 18'sh4f47,
		18'sh60c3, 18'sh7460, 18'sh8a62, 18'sha312, 18'shbed2};

	function automatic data_t sat_data(input logic signed [47:0] v);
		if (v[47:DATA_W-1] == '0 || v[47:DATA_W-1] == '1)
			return v[DATA_W-1:0];
		return v[47] ? {1'b1, {(DATA_W-1){1'b0}}} : {1'b0, {(DATA_W-1){1'b1}}};
	endfunction

	function automatic logic [SAMPLE_W-1:0] sat_sample(input data_t v);
		if (v[DATA_W-1:SAMPLE_W-1] == '0 || v[DATA_W-1:SAMPLE_W-1] == '1)
			return v[SAMPLE_W-1:0];
		return v[DATA_W-1] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
	endfunction
endpackage

/* eq_coef_if.sv */
// eq_coef_if: per-band coefficient set from selector to datapath
// assumes both ends share the equaliser clock
`timescale 1ns/1ps
interface eq_coef_if;
	import eq_pkg::*;
	coef_t b0  [NUM_BANDS];
	coef_t a1  [NUM_BANDS];
	coef_t a2  [NUM_BANDS];
	gm1_t  gm1 [NUM_BANDS];
	modport src (output b0, output a1, output a2, output gm1);
	modport dst (input b0, input a1, input a2, input gm1);
endinterface

/* eq_coeff_sel.sv */
// eq_coeff_sel: picks fixed or programmed band shapes and decodes gains
// assumes register values are stable between bus writes
`timescale 1ns/1ps
module eq_coeff_sel (
	// control
	input  wire logic                         custom_mode_i,
	input  wire logic [eq_pkg::GCODE_W-1:0]   gain_code_i [eq_pkg::NUM_BANDS],
	input  wire logic [eq_pkg::REG_W-1:0]     cust_i [eq_pkg::NUM_CUST],
	// coefficients
	eq_coef_if.src                            coef
);
	import eq_pkg::*;

	// reserved codes fall back to flat
	function automatic gm1_t gain_lookup(input logic [GCODE_W-1:0] code);
		if (code > GCODE_MAX)
			return '0;
		return GAIN_M1[code];
	endfunction

	genvar b;
	generate
		for (b = 0; b < NUM_BANDS; b++) begin : g_band
			assign coef.b0[b]  = custom_mode_i ? coef_t'(cust_i[3*b])   : DEF_B0[b]; // see RULE3 see RULE10
			assign coef.a1[b]  = custom_mode_i ? coef_t'(cust_i[3*b+1]) : DEF_A1[b]; // see RULE4 see RULE12
			assign coef.a2[b]  = custom_mode_i ? coef_t'(cust_i[3*b+2]) : DEF_A2[b]; // see RULE5 see RULE6
			assign coef.gm1[b] = gain_lookup(gain_code_i[b]); // see RULE7 see RULE11
		end
	endgenerate
endmodule

/* eq_band_mac.sv */
// eq_band_mac: one band step, shape filter plus gain blend
// assumes history and coefficients are valid when used
`timescale 1ns/1ps
module eq_band_mac (
	// band
	input  wire eq_pkg::band_type_t type_i,
	input  wire eq_pkg::coef_t      b0_i,
	input  wire eq_pkg::coef_t      a1_i,
	input  wire eq_pkg::coef_t      a2_i,
	input  wire eq_pkg::gm1_t       gm1_i,
	// samples
	input  wire eq_pkg::data_t      x_i,
	input  wire eq_pkg::data_t      x1_i,
	input  wire eq_pkg::data_t      x2_i,
	input  wire eq_pkg::data_t      h1_i,
	input  wire eq_pkg::data_t      h2_i,
	// results
	output eq_pkg::data_t           h_o,
	output eq_pkg::data_t           y_o
);
	import eq_pkg::*;

	logic signed [DATA_W:0] s;
	logic signed [47:0]     acc;
	logic signed [47:0]     boost;

	always_comb begin
		case (type_i)
			BT_PEAK:       s = (DATA_W+1)'(x_i) - (DATA_W+1)'(x2_i); // see RULE13
			BT_HIGH_SHELF: s = (DATA_W+1)'(x_i) - (DATA_W+1)'(x1_i); // see RULE14
			default:       s = (DATA_W+1)'(x_i); // see RULE13
		endcase
		acc   = 48'(b0_i * s) - 48'(a1_i * h1_i) - 48'(a2_i * h2_i);
		h_o   = sat_data(acc >>> FRAC_W);
		boost = 48'(gm1_i * h_o) >>> FRAC_W;
		y_o   = sat_data(48'(x_i) + boost); // see RULE14
	end
endmodule

/* five_band_parametric_eq.sv */
// five_band_parametric_eq: five-band equaliser in the playback path
// with its register file on a classic Wishbone slave.
// assumes one sample handshake at a time and a 10 MHz clock,
// far faster than the audio sample rate.
//
// Operation
// RULE1: processing only while enable bit set
// RULE2: every sample toward DAC passes here
// RULE3: default and custom coefficient modes exist
// RULE4: default bands 100,300,875,2400,6900 Hz at 48k
// RULE5: default bandwidths fixed, only gains change
// RULE6: band frequencies scale with sample rate
// RULE7: 5-bit gain code, 1 dB steps
// RULE8: first register holds bands 1-3, enable
// RULE9: second register holds bands 4 and 5
// RULE10: custom mode takes band shapes from registers
// RULE11: enable and gains identical in both modes
// RULE12: custom coefficients in registers 44 to 61
// RULE13: band 1 low shelf, bands 2-4 peaking
// RULE14: band 5 high shelf with gain code
// RULE15: disabled means samples pass unchanged
// RULE16: software avoids reserved codes, loads coefficients first
`timescale 1ns/1ps
module five_band_parametric_eq (
	// clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           rst_i,
	// wishbone slave
	input  wire logic                           wb_cyc_i,
	input  wire logic                           wb_stb_i,
	input  wire logic                           wb_we_i,
	input  wire logic [eq_pkg::WB_ADR_W-1:0]    wb_adr_i,
	input  wire logic [3:0]                     wb_sel_i,
	input  wire logic [eq_pkg::WB_DAT_W-1:0]    wb_dat_i,
	output logic      [eq_pkg::WB_DAT_W-1:0]    wb_dat_o,
	output logic                                wb_ack_o,
	// sample input from the audio path
	input  wire logic [eq_pkg::SAMPLE_W-1:0]    sample_i,
	input  wire logic                           sample_valid_i,
	output logic                                sample_ready_o,
	// sample output toward the interpolator
	output logic      [eq_pkg::SAMPLE_W-1:0]    sample_o,
	output logic                                sample_valid_o,
	input  wire logic                           sample_ready_i
);
	import eq_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_HOLD = 2'b10
	} stream_state_t;

	localparam logic [2:0] LAST_BAND = 3'(NUM_BANDS - 1);

	// bus state
	logic                 ack_reg;
	logic                 ack_next;
	logic [WB_DAT_W-1:0]  rdat_reg;
	logic [WB_DAT_W-1:0]  rdat_next;

	// register file
	logic [REG_W-1:0]     ctrl_one_reg;
	logic [REG_W-1:0]     ctrl_one_next;
	logic [REG_W-1:0]     ctrl_two_reg;
	logic [REG_W-1:0]     ctrl_two_next;
	logic [REG_W-1:0]     mode_reg;
	logic [REG_W-1:0]     mode_next;
	logic [REG_W-1:0]     cust_reg  [NUM_CUST];
	logic [REG_W-1:0]     cust_next [NUM_CUST];

	// stream state
	stream_state_t        st_reg;
	stream_state_t        st_next;
	logic [2:0]           band_reg;
	logic [2:0]           band_next;
	data_t                cur_reg;
	data_t                cur_next;
	logic [SAMPLE_W-1:0]  out_reg;
	logic [SAMPLE_W-1:0]  out_next;
	data_t                x1_reg [NUM_BANDS];
	data_t                x1_next [NUM_BANDS];
	data_t                x2_reg [NUM_BANDS];
	data_t                x2_next [NUM_BANDS];
	data_t                h1_reg [NUM_BANDS];
	data_t                h1_next [NUM_BANDS];
	data_t                h2_reg [NUM_BANDS];
	data_t                h2_next [NUM_BANDS];

	// decoded controls
	logic [IDX_W-1:0]     idx;
	logic                 adr_hit;
	logic                 req;
	logic                 wr_take;
	logic                 equalizer_on;
	logic                 custom_coefficient_mode;
	logic [GCODE_W-1:0]   gain_code [NUM_BANDS];
	data_t                mac_h;
	data_t                mac_y;

	eq_coef_if coef ();

	// address decode

	assign idx     = wb_adr_i[IDX_W+1:2];
	assign adr_hit = (wb_adr_i[WB_ADR_W-1:IDX_W+2] == '0);
	assign req     = wb_cyc_i && wb_stb_i;
	// writes land on the edge where the master sees ack
	assign wr_take = req && wb_we_i && ack_reg && adr_hit;

	function automatic logic is_cust(input logic [IDX_W-1:0] i);
		return (i >= IDX_CUST_FIRST) && (i <= IDX_CUST_LAST);
	endfunction

	function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old, input logic [REG_W-1:0] d,
	                                              input logic [1:0] sel);
		logic [REG_W-1:0] r;
		r = old;
		if (sel[0])
			r[7:0] = d[7:0];
		if (sel[1])
			r[15:8] = d[15:8];
		return r;
	endfunction

	// field extraction, same in both modes
	assign equalizer_on            = ctrl_one_reg[ENA_POS]; // see RULE1 see RULE11
	assign custom_coefficient_mode = mode_reg[MODE_POS]; // see RULE3
	assign gain_code[0] = ctrl_one_reg[B1_POS +: GCODE_W]; // see RULE8
	assign gain_code[1] = ctrl_one_reg[B2_POS +: GCODE_W]; // see RULE8
	assign gain_code[2] = ctrl_one_reg[B3_POS +: GCODE_W]; // see RULE8
	assign gain_code[3] = ctrl_two_reg[B4_POS +: GCODE_W]; // see RULE9
	assign gain_code[4] = ctrl_two_reg[B5_POS +: GCODE_W]; // see RULE9

	// bus answer

	function automatic logic [REG_W-1:0] read_reg(input logic [IDX_W-1:0] i);
		logic [REG_W-1:0] r;
		r = '0;
		case (i)
			IDX_CTRL_ONE: r = ctrl_one_reg;
			IDX_CTRL_TWO: r = ctrl_two_reg & CTRL_TWO_MASK;
			IDX_MODE:     r = mode_reg & MODE_MASK;
			IDX_STATUS: begin
				r[BUSY_POS] = (st_reg != ST_IDLE);
				r[HOLD_POS] = (st_reg == ST_HOLD);
			end
			default: begin
				if (is_cust(i))
					r = cust_reg[5'(i - IDX_CUST_FIRST)]; // see RULE12
			end
		endcase
		return r;
	endfunction

	always_comb begin
		ack_next  = req && !ack_reg;
		rdat_next = rdat_reg;
		if (req && !ack_reg) begin
			rdat_next = '0;
			if (adr_hit && !wb_we_i)
				rdat_next = {{(WB_DAT_W-REG_W){1'b0}}, read_reg(idx)};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg  <= 1'b0;
			rdat_reg <= '0;
		end else begin
			ack_reg  <= ack_next;
			rdat_reg <= rdat_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// register writes

	always_comb begin
		ctrl_one_next = ctrl_one_reg;
		ctrl_two_next = ctrl_two_reg;
		mode_next     = mode_reg;
		cust_next     = cust_reg;
		if (wr_take) begin
			case (idx)
				IDX_CTRL_ONE: ctrl_one_next = merge16(ctrl_one_reg, wb_dat_i[REG_W-1:0], wb_sel_i[1:0]); // see RULE8
				IDX_CTRL_TWO: ctrl_two_next = merge16(ctrl_two_reg, wb_dat_i[REG_W-1:0], wb_sel_i[1:0])
				                              & CTRL_TWO_MASK; // see RULE9
				IDX_MODE:     mode_next = merge16(mode_reg, wb_dat_i[REG_W-1:0], wb_sel_i[1:0]) & MODE_MASK;
				default: begin
					if (is_cust(idx))
						cust_next[5'(idx - IDX_CUST_FIRST)] = merge16(cust_reg[5'(idx - IDX_CUST_FIRST)],
						                                              wb_dat_i[REG_W-1:0], wb_sel_i[1:0]); // see RULE12
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_one_reg <= CTRL_ONE_RST;
			ctrl_two_reg <= CTRL_TWO_RST;
			mode_reg     <= MODE_RST;
			cust_reg     <= '{default: CUST_RST};
		end else begin
			ctrl_one_reg <= ctrl_one_next;
			ctrl_two_reg <= ctrl_two_next;
			mode_reg     <= mode_next;
			cust_reg     <= cust_next;
		end
	end

	// coefficients and band arithmetic

	eq_coeff_sel u_coeff (
		.custom_mode_i (custom_coefficient_mode),
		.gain_code_i   (gain_code),
		.cust_i        (cust_reg),
		.coef          (coef)
	);

	eq_band_mac u_mac (
		.type_i (BAND_TYPE[band_reg]),
		.b0_i   (coef.b0[band_reg]),
		.a1_i   (coef.a1[band_reg]),
		.a2_i   (coef.a2[band_reg]),
		.gm1_i  (coef.gm1[band_reg]),
		.x_i    (cur_reg),
		.x1_i   (x1_reg[band_reg]),
		.x2_i   (x2_reg[band_reg]),
		.h1_i   (h1_reg[band_reg]),
		.h2_i   (h2_reg[band_reg]),
		.h_o    (mac_h),
		.y_o    (mac_y)
	);

	// sample sequencing, one band per cycle

	always_comb begin
		st_next   = st_reg;
		band_next = band_reg;
		cur_next  = cur_reg;
		out_next  = out_reg;
		x1_next   = x1_reg;
		x2_next   = x2_reg;
		h1_next   = h1_reg;
		h2_next   = h2_reg;
		case (st_reg)
			ST_IDLE: begin
				if (sample_valid_i) begin
					cur_next  = DATA_W'($signed(sample_i));
					band_next = '0;
					if (equalizer_on) begin
						st_next = ST_RUN; // see RULE1 see RULE2
					end else begin
						out_next = sample_i; // see RULE15
						st_next  = ST_HOLD;
					end
				end
			end
			ST_RUN: begin
				x1_next[band_reg] = cur_reg;
				x2_next[band_reg] = x1_reg[band_reg];
				h1_next[band_reg] = mac_h;
				h2_next[band_reg] = h1_reg[band_reg];
				cur_next          = mac_y; // see RULE2
				if (band_reg == LAST_BAND) begin
					out_next = sat_sample(mac_y);
					st_next  = ST_HOLD;
				end else begin
					band_next = band_reg + 3'h1;
				end
			end
			ST_HOLD: begin
				if (sample_ready_i)
					st_next = ST_IDLE;
			end
			default: st_next = ST_IDLE;
		endcase
		// history restarts clean when re-enabled
		if (!equalizer_on) begin
			x1_next = '{default: '0}; // see RULE15
			x2_next = '{default: '0};
			h1_next = '{default: '0};
			h2_next = '{default: '0};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg   <= ST_IDLE;
			band_reg <= '0;
			cur_reg  <= '0;
			out_reg  <= '0;
			x1_reg   <= '{default: '0};
			x2_reg   <= '{default: '0};
			h1_reg   <= '{default: '0};
			h2_reg   <= '{default: '0};
		end else begin
			st_reg   <= st_next;
			band_reg <= band_next;
			cur_reg  <= cur_next;
			out_reg  <= out_next;
			x1_reg   <= x1_next;
			x2_reg   <= x2_next;
			h1_reg   <= h1_next;
			h2_reg   <= h2_next;
		end
	end

	assign sample_ready_o = (st_reg == ST_IDLE);
	assign sample_valid_o = (st_reg == ST_HOLD);
	assign sample_o       = out_reg;

	// checks

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_ENABLED_RUNS: assert property ( // see RULE1
		(st_reg == ST_IDLE && sample_valid_i && equalizer_on) |=> (st_reg == ST_RUN && band_reg == 3'h0)
	) else $error("enabled sample did not start band processing");

	AST_FIVE_BANDS: assert property ( // see RULE2
		(st_reg == ST_IDLE && sample_valid_i && equalizer_on) |=> (st_reg == ST_RUN) [*5] ##1 (st_reg == ST_HOLD)
	) else $error("sample did not pass through all five bands");

	AST_BYPASS_EXACT: assert property ( // see RULE15
		(st_reg == ST_IDLE && sample_valid_i && !equalizer_on)
		|=> (sample_valid_o && sample_o == $past(sample_i))
	) else $error("disabled path altered the sample");

	AST_HOLD_STABLE: assert property ( // see RULE2
		(sample_valid_o && !sample_ready_i) |=> (sample_valid_o && $stable(sample_o))
	) else $error("output sample dropped under back-pressure");

	AST_FLAT_CODE: assert property ( // see RULE7
		(gain_code[2] == GCODE_FLAT) |-> (coef.gm1[2] == '0 && coef.gm1[2] != GAIN_M1[0])
	) else $error("flat gain code gave nonzero boost");

	AST_GAIN_WRITE: assert property ( // see RULE8
		(wr_take && idx == IDX_CTRL_ONE && wb_sel_i[1:0] == 2'b11)
		|=> (gain_code[0] == $past(wb_dat_i[15:11]) && equalizer_on == $past(wb_dat_i[0]))
	) else $error("first control register fields misplaced");

	AST_SECOND_REG: assert property ( // see RULE9
		(wr_take && idx == IDX_CTRL_TWO && wb_sel_i[1:0] == 2'b11)
		|=> (gain_code[3] == $past(wb_dat_i[15:11]) && gain_code[4] == $past(wb_dat_i[10:6]))
	) else $error("second control register fields misplaced");

	AST_DEFAULT_SHAPE: assert property ( // see RULE4
		!custom_coefficient_mode |-> (coef.b0[0] == DEF_B0[0] && coef.a1[4] == DEF_A1[4] && coef.a2[2] == DEF_A2[2])
	) else $error("default mode used programmed band shapes");

	AST_CUSTOM_SHAPE: assert property ( // see RULE10
		custom_coefficient_mode |-> (coef.b0[0] == coef_t'(cust_reg[0]) && coef.a2[4] == coef_t'(cust_reg[14]))
	) else $error("custom mode ignored programmed coefficients");

	AST_BUS_ACK: assert property ( // see RULE12
		(req && !ack_reg) |=> (ack_reg ##1 !ack_reg)
	) else $error("bus answer not a single-cycle ack");

	COV_BYPASS: cover property ((st_reg == ST_IDLE && sample_valid_i && !equalizer_on) ##1 sample_valid_o);
	COV_EQ_SAMPLE: cover property ((st_reg == ST_RUN && band_reg == LAST_BAND) ##1 sample_valid_o);
	COV_CUSTOM: cover property (custom_coefficient_mode && st_reg == ST_RUN);
	COV_STALL: cover property (sample_valid_o && !sample_ready_i ##1 sample_valid_o && sample_ready_i);
endmodule

/* far_end_model.sv */
// far_end_model: downstream interpolator taking output samples
// assumes the equaliser clock; stalls a set number of cycles per sample
`timescale 1ns/1ps
module far_end_model (
	// clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	// stream from the equaliser
	input  wire logic [eq_pkg::SAMPLE_W-1:0] sample_i,
	input  wire logic                        valid_i,
	output logic                             ready_o,
	// bench side
	input  wire logic [3:0]                  stall_i,
	output logic      [eq_pkg::SAMPLE_W-1:0] last_o,
	output logic                             hold_err_o
);
	logic [3:0]                  wait_reg;
	logic [eq_pkg::SAMPLE_W-1:0] first_reg;

	// ready only after the stall, dropped right after each taken sample
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wait_reg <= 4'h0;
			ready_o <= 1'b0;
			last_o <= 24'h000000;
			hold_err_o <= 1'b0;
		end else if (valid_i && ready_o) begin
			ready_o <= 1'b0;
			wait_reg <= 4'h0;
			last_o <= sample_i;
			if (sample_i !== first_reg)
				hold_err_o <= 1'b1;
		end else if (valid_i) begin
			if (wait_reg == 4'h0)
				first_reg <= sample_i;
			if (wait_reg >= stall_i)
				ready_o <= 1'b1;
			else
				wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule

/* tb_five_band_parametric_eq.sv */
// tb_five_band_parametric_eq: register and sample stream tests
// assumes the far-end model as sample sink and a 10 MHz clock
`timescale 1ns/1ps
module tb_five_band_parametric_eq;
	import eq_pkg::*;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i, stall;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [23:0] sample_i, sample_o, last;
	logic        sample_valid_i, sample_ready_o, sample_valid_o, sample_ready_i, hold_err, hs;
	int          failures, compares;
	assign hs = sample_valid_o & sample_ready_i;

	five_band_parametric_eq dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .sample_i(sample_i), .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
		.sample_o(sample_o), .sample_valid_o(sample_valid_o), .sample_ready_i(sample_ready_i));
	far_end_model sink (.clk_i(clk_i), .rst_i(rst_i), .sample_i(sample_o), .valid_i(sample_valid_o),
		.ready_o(sample_ready_i), .stall_i(stall), .last_o(last), .hold_err_o(hold_err));

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// which: 0 ack, 1 input ready, 2 output valid, 3 output handshake
	task automatic wait_edge(input int which, output int n);
		logic s;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			case (which)
				0: s = wb_ack_o;
				1: s = sample_ready_o;
				2: s = sample_valid_o;
				default: s = hs;
			endcase
		end while (s !== 1'b1 && n < 60);
		if (n >= 60)
			check("handshake wait", 32'h1, 32'h0);
	endtask

	task automatic wb(input logic we, input logic [11:0] adr, input logic [15:0] d, output logic [15:0] q);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h3;
		wb_dat_i <= {16'h0000, d};
		wait_edge(0, n);
		q = wb_dat_o[15:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic send(input logic [23:0] x, input int lat, output logic [23:0] y);
		int n;
		sample_i <= x;
		sample_valid_i <= 1'b1;
		wait_edge(1, n);
		sample_valid_i <= 1'b0;
		wait_edge(2, n);
		check("latency", 32'(lat), 32'(n));
		if (hs !== 1'b1)
			wait_edge(3, n);
		@(posedge clk_i);
		y = last;
	endtask

	task automatic summarize();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	initial begin
		#2000000;
		failures++;
		summarize();
	end

	initial begin
		logic [15:0] q;
		logic [23:0] y, prev, yd;
		logic [4:0]  g [5];
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, sample_valid_i} = 4'h0;
		wb_adr_i = 12'h000;
		wb_sel_i = 4'h3;
		wb_dat_i = 32'h0;
		sample_i = 24'h0;
		stall = 4'h5;
		failures = 0;
		compares = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, 12'h0a8, 16'h0, q); check("ctrl_one reset", 32'h0, 32'(q));
		wb(1'b0, 12'h0ac, 16'h0, q); check("ctrl_two reset", 32'h0, 32'(q));
		wb(1'b0, 12'h0f8, 16'h0, q); check("mode reset", 32'h0, 32'(q));
		send(24'h123456, 1, y); check("bypass stalled", 32'h123456, 32'(y));
		stall <= 4'h0;
		send(24'h800001, 1, y); check("bypass negative", 32'h800001, 32'(y));
		wb(1'b1, 12'h0a8, 16'hfffe, q);
		wb(1'b0, 12'h0a8, 16'h0, q); check("ctrl_one fields", 32'hfffe, 32'(q));
		send(24'h2468ac, 1, y); check("disabled with gains", 32'h2468ac, 32'(y));
		wb(1'b1, 12'h0ac, 16'hffff, q);
		wb(1'b0, 12'h0ac, 16'h0, q); check("ctrl_two fields", 32'hffc0, 32'(q));
		wb(1'b1, 12'h4a8, 16'h1234, q);
		wb(1'b0, 12'h4a8, 16'h0, q); check("unmapped read", 32'h0, 32'(q));
		wb(1'b0, 12'h0a8, 16'h0, q); check("alias write ignored", 32'hfffe, 32'(q));
		for (int k = 0; k < 18; k++)
			wb(1'b1, 12'h0b0 + 12'(4 * k), 16'h0a00 + 16'(k), q);
		for (int k = 0; k < 18; k++) begin
			wb(1'b0, 12'h0b0 + 12'(4 * k), 16'h0, q); check("custom reg", 32'h0a00 + k, 32'(q));
		end
		wb(1'b1, 12'h0ac, 16'h6300, q);
		wb(1'b1, 12'h0a8, 16'h6319, q);
		foreach (g[i]) begin
			send(24'h100000 ^ 24'(i * 24'h0f0f01), 6, y);
			check("flat gains", 32'h100000 ^ 32'(i * 24'h0f0f01), 32'(y));
		end
		for (int b = 0; b < 5; b++)
			for (int c = 0; c < 25; c++) begin
				foreach (g[i])
					g[i] = 5'h0c;
				g[b] = 5'(c);
				wb(1'b1, 12'h0a8, 16'h0000, q);
				wb(1'b1, 12'h0ac, {g[3], g[4], 6'h00}, q);
				wb(1'b1, 12'h0a8, {g[0], g[1], g[2], 1'b1}, q);
				send(24'h100000, 6, y);
				if (c == 12)
					check("unity gain code", 32'h100000, 32'(y));
				if (c > 0)
					check("gain steps up", 32'h1, 32'($signed(y) > $signed(prev)));
				if (b == 0 && c == 0)
					yd = y;
				prev = y;
			end
		// coefficients loaded before enabling in custom mode
		wb(1'b1, 12'h0a8, 16'h0000, q);
		for (int k = 0; k < 18; k++)
			wb(1'b1, 12'h0b0 + 12'(4 * k), (k == 0) ? 16'h2000 : 16'h0000, q);
		wb(1'b1, 12'h0f8, 16'h0001, q);
		wb(1'b0, 12'h0f8, 16'h0, q); check("mode set", 32'h1, 32'(q));
		wb(1'b1, 12'h0ac, 16'h6300, q);
		wb(1'b1, 12'h0a8, 16'h0319, q);
		send(24'h100000, 6, y);
		check("custom shape", 32'h1, 32'($signed(y) > 24'sh0a0278 && $signed(y) < 24'sh0a0288));
		wb(1'b1, 12'h0a8, 16'h0318, q);
		wb(1'b1, 12'h0f8, 16'h0000, q);
		wb(1'b1, 12'h0a8, 16'h0319, q);
		send(24'h100000, 6, y); check("back to default", 32'(yd), 32'(y));
		wb(1'b0, 12'h0fc, 16'h0, q); check("status idle", 32'h0, 32'(q));
		check("output held while stalled", 32'h0, 32'(hold_err));
		summarize();
	end
endmodule
